// ---- adc_cfg_pkg.sv ----
/*
 Constants shared by the converter configuration and serializer logic.
 Assumes a single 125 MHz sample-domain clock drives every user.
*/
package adc_cfg_pkg;

   // -----------------------------------------------------------------
   // Register map
   // -----------------------------------------------------------------
   localparam logic [7:0] ADDR_CORE_POWER_VCM = 8'h50;
   localparam logic [7:0] ADDR_OUT_BITS = 8'h53;
   localparam logic [7:0] ADDR_FULL_SCALE = 8'h55;
   localparam logic [7:0] ADDR_CLOCK_RANGE = 8'h56;

   localparam int PERF_LSB = 0;
   localparam int PERF_MSB = 2;
   localparam int VCM_LSB = 4;
   localparam int VCM_MSB = 5;
   localparam int NUM_BITS_POS = 1;
   localparam int TRIM_LSB = 0;
   localparam int TRIM_MSB = 5;
   localparam int RANGE_LSB = 0;
   localparam int RANGE_MSB = 1;

   localparam logic [2:0] PERF_RESET = 3'h0;
   localparam logic [1:0] VCM_RESET = 2'h1;
   localparam logic [5:0] TRIM_RESET = 6'h20;
   localparam logic [1:0] RANGE_RESET = 2'h0;

   localparam logic [1:0] VCM_OFF = 2'h0;

   // -----------------------------------------------------------------
   // Serial control frame: 8-bit address then 16-bit data, MSB first
   // -----------------------------------------------------------------
   localparam int CTRL_FRAME_BITS = 24;
   localparam logic [4:0] CTRL_FRAME_LEN = 5'd24;

   // -----------------------------------------------------------------
   // Start-up counts per clock range
   // -----------------------------------------------------------------
   localparam logic [9:0] STARTUP_R0 = 10'd992;
   localparam logic [9:0] STARTUP_R1 = 10'd640;
   localparam logic [9:0] STARTUP_R2 = 10'd420;
   localparam logic [9:0] STARTUP_R3 = 10'd260;

   // -----------------------------------------------------------------
   // Serializer
   // -----------------------------------------------------------------
   localparam int NUM_CH = 8;
   localparam int CODE_W = 13;
   localparam int WORD_W = 14;
   localparam logic [3:0] LEN_12 = 4'd12;
   localparam logic [3:0] LEN_14 = 4'd14;

endpackage

// ---- adc_lane_serializer.sv ----
/*
 One output lane: formats a 13-bit conversion code into a 12- or
 14-bit word and shifts it out LSB first.
 Assumes the bit index and load pulse come from the frame counter.
*/
`timescale 1ns/1ps

module adc_lane_serializer
   import adc_cfg_pkg::*;
(
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   input wire logic i_load,
   input wire logic i_width14,
   input wire logic [3:0] i_next_idx,
   input wire logic [CODE_W-1:0] i_code,
   output logic o_lane
);

   // -----------------------------------------------------------------
   // Word formatting
   // -----------------------------------------------------------------
   function automatic logic [WORD_W-1:0] fmt_word(
      input logic [CODE_W-1:0] code,
      input logic width14
   );
      if (width14)
         fmt_word = {code, 1'b0};
      else
         fmt_word = {2'b00, code[CODE_W-1:1]};
   endfunction

   logic [WORD_W-1:0] word_q;
   logic [WORD_W-1:0] src;
   logic lane_q;

   always_comb
   begin
      src = i_load ? fmt_word(i_code, i_width14) : word_q;
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rst_n)
         word_q <= '0;
      else if (i_load)
         word_q <= fmt_word(i_code, i_width14);
   end

   // One bit per bit period, LSB first
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rst_n)
         lane_q <= 1'b0;
      else
         lane_q <= src[i_next_idx];
   end

   assign o_lane = lane_q;

endmodule

// ---- adc_trim_and_startup_ctrl.sv ----
/*
 Configuration registers, start-up counter and serial output framing
 of an eight-channel converter.
 Assumes serial control pins are asynchronous; conversion codes come
 from logic on the same sample clock.
*/
`timescale 1ns/1ps

module adc_trim_and_startup_ctrl
   import adc_cfg_pkg::*;
(
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   input wire logic i_ctrl_sclk,
   input wire logic i_ctrl_sdata,
   input wire logic i_ctrl_sen_n,
   input wire logic i_power_down,
   input wire logic i_deep_sleep,
   input wire logic [NUM_CH*CODE_W-1:0] i_conv_code,
   output logic [5:0] o_full_scale_trim,
   output logic [5:0] o_trim_steps,
   output logic [2:0] o_core_perf,
   output logic o_core_perf_reserved,
   output logic [1:0] o_common_mode_buffer_strength,
   output logic o_cm_buffer_enable,
   output logic [1:0] o_clock_range,
   output logic o_width14,
   output logic o_outputs_valid,
   output logic [NUM_CH-1:0] o_lane,
   output logic o_frame_clock,
   output logic o_bit_clock
);

   // -----------------------------------------------------------------
   // Pin synchronisers
   // -----------------------------------------------------------------
   logic [4:0] sync1_q;
   logic [4:0] sync2_q;
   logic sclk_prev_q;
   logic sen_prev_q;

   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rst_n)
      begin
         sync1_q <= 5'h04;
         sync2_q <= 5'h04;
         sclk_prev_q <= 1'b0;
         sen_prev_q <= 1'b1;
      end
      else
      begin
         sync1_q <= {i_deep_sleep, i_power_down, i_ctrl_sen_n,
                     i_ctrl_sdata, i_ctrl_sclk};
         sync2_q <= sync1_q;
         sclk_prev_q <= sync2_q[0];
         sen_prev_q <= sync2_q[2];
      end
   end

   logic sclk_rise;
   logic sen_rise;
   logic sleep_req;
   assign sclk_rise = sync2_q[0] & ~sclk_prev_q;
   assign sen_rise = sync2_q[2] & ~sen_prev_q;
   assign sleep_req = sync2_q[3] | sync2_q[4];

   // -----------------------------------------------------------------
   // Serial control receiver
   // -----------------------------------------------------------------
   logic [CTRL_FRAME_BITS-1:0] shift_q;
   logic [4:0] bits_q;

   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rst_n)
      begin
         shift_q <= '0;
         bits_q <= '0;
      end
      else if (sync2_q[2])
         bits_q <= '0;
      else if (sclk_rise)
      begin
         shift_q <= {shift_q[CTRL_FRAME_BITS-2:0], sync2_q[1]};
         if (bits_q != CTRL_FRAME_LEN)
            bits_q <= bits_q + 5'd1;
      end
   end

   logic wr_en;
   logic [7:0] wr_addr;
   logic [15:0] wr_data;
   assign wr_en = sen_rise & (bits_q == CTRL_FRAME_LEN);
   assign wr_addr = shift_q[23:16];
   assign wr_data = shift_q[15:0];

   // -----------------------------------------------------------------
   // Registers
   // -----------------------------------------------------------------
   logic [2:0] perf_q;
   logic [1:0] vcm_q;
   logic [5:0] trim_q;
   logic [1:0] range_q;
   logic width14_q;

   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rst_n)
      begin
         perf_q <= PERF_RESET;
         vcm_q <= VCM_RESET;
      end
      else if (wr_en && wr_addr == ADDR_CORE_POWER_VCM)
      begin
         perf_q <= wr_data[PERF_MSB:PERF_LSB];
         vcm_q <= wr_data[VCM_MSB:VCM_LSB];
      end
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rst_n)
         trim_q <= TRIM_RESET;
      else if (wr_en && wr_addr == ADDR_FULL_SCALE)
         trim_q <= wr_data[TRIM_MSB:TRIM_LSB];
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rst_n)
         range_q <= RANGE_RESET;
      else if (wr_en && wr_addr == ADDR_CLOCK_RANGE)
         range_q <= wr_data[RANGE_MSB:RANGE_LSB];
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rst_n)
         width14_q <= 1'b0;
      else if (wr_en && wr_addr == ADDR_OUT_BITS)
         width14_q <= wr_data[NUM_BITS_POS];
   end

   // -----------------------------------------------------------------
   // Decoded settings
   // -----------------------------------------------------------------
   logic [5:0] trim_out_q;
   logic [5:0] steps_q;
   logic [2:0] perf_out_q;
   logic perf_rsv_q;
   logic [1:0] vcm_out_q;
   logic vcm_en_q;
   logic [1:0] range_out_q;
   logic width_out_q;

   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rst_n)
      begin
         trim_out_q <= TRIM_RESET;
         steps_q <= '0;
         perf_out_q <= PERF_RESET;
         perf_rsv_q <= 1'b0;
         vcm_out_q <= VCM_RESET;
         vcm_en_q <= 1'b1;
         range_out_q <= RANGE_RESET;
         width_out_q <= 1'b0;
      end
      else
      begin
         trim_out_q <= trim_q;
         // Signed step count, 0x20 maps to zero
         steps_q <= trim_q ^ TRIM_RESET;
         perf_out_q <= perf_q;
         // Codes 001..011 flagged
         perf_rsv_q <= ~perf_q[2] & (perf_q[1:0] != 2'b00);
         vcm_out_q <= vcm_q;
         vcm_en_q <= (vcm_q != VCM_OFF);
         range_out_q <= range_q;
         width_out_q <= width14_q;
      end
   end

   // -----------------------------------------------------------------
   // Start-up counter
   // -----------------------------------------------------------------
   function automatic logic [9:0] startup_count(input logic [1:0] rng);
      unique case (rng)
         2'b00: startup_count = STARTUP_R0;
         2'b01: startup_count = STARTUP_R1;
         2'b10: startup_count = STARTUP_R2;
         2'b11: startup_count = STARTUP_R3;
      endcase
   endfunction

   typedef enum logic [1:0] {ST_ASLEEP, ST_WAKING, ST_ACTIVE} wake_e;
   wake_e wake_q;
   logic [9:0] wake_cnt_q;
   logic valid_q;

   // Reset, power-down and deep-sleep exits all use the counter
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rst_n)
      begin
         wake_q <= ST_WAKING;
         wake_cnt_q <= '0;
         valid_q <= 1'b0;
      end
      else if (sleep_req)
      begin
         wake_q <= ST_ASLEEP;
         wake_cnt_q <= '0;
         valid_q <= 1'b0;
      end
      else
      begin
         unique case (wake_q)
            ST_ASLEEP:
            begin
               wake_q <= ST_WAKING;
               wake_cnt_q <= '0;
            end
            ST_WAKING:
            begin
               wake_cnt_q <= wake_cnt_q + 10'd1;
               if (wake_cnt_q + 10'd1 >= startup_count(range_q))
               begin
                  wake_q <= ST_ACTIVE;
                  valid_q <= 1'b1;
               end
            end
            ST_ACTIVE:
               valid_q <= 1'b1;
         endcase
      end
   end

   // -----------------------------------------------------------------
   // Frame counter and output clocks
   // -----------------------------------------------------------------
   logic [3:0] bit_idx_q;
   logic frame_width14_q;
   logic [3:0] frame_len;
   logic [3:0] next_idx;
   logic frame_load;
   logic next_width14;
   logic [3:0] next_len;
   logic frame_clk_q;
   logic bit_clk_q;

   assign frame_len = frame_width14_q ? LEN_14 : LEN_12;
   assign frame_load = (bit_idx_q == frame_len - 4'd1);
   assign next_idx = frame_load ? 4'd0 : bit_idx_q + 4'd1;
   // Width changes only at a frame boundary
   assign next_width14 = frame_load ? width14_q : frame_width14_q;
   assign next_len = next_width14 ? LEN_14 : LEN_12;

   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rst_n)
      begin
         bit_idx_q <= LEN_12 - 4'd1;
         frame_width14_q <= 1'b0;
         frame_clk_q <= 1'b0;
         bit_clk_q <= 1'b0;
      end
      else
      begin
         bit_idx_q <= next_idx;
         frame_width14_q <= next_width14;
         // 1x frame clock high for first half of the word
         frame_clk_q <= (next_idx < {1'b0, next_len[3:1]});
         // Toggle per bit: 6x clock for a 12-bit word
         bit_clk_q <= ~bit_clk_q;
      end
   end

   // -----------------------------------------------------------------
   // Lanes, all loaded from the one clock
   // -----------------------------------------------------------------
   for (genvar ch = 0; ch < NUM_CH; ch++)
   begin : g_lane
      // Code 0 is most negative, 8191 most positive
      adc_lane_serializer u_lane (
         .i_ref_clk(i_ref_clk),
         .i_rst_n(i_rst_n),
         .i_load(frame_load),
         .i_width14(width14_q),
         .i_next_idx(next_idx),
         .i_code(i_conv_code[ch*CODE_W +: CODE_W]),
         .o_lane(o_lane[ch])
      );
   end

   assign o_full_scale_trim = trim_out_q;
   assign o_trim_steps = steps_q;
   assign o_core_perf = perf_out_q;
   assign o_core_perf_reserved = perf_rsv_q;
   assign o_common_mode_buffer_strength = vcm_out_q;
   assign o_cm_buffer_enable = vcm_en_q;
   assign o_clock_range = range_out_q;
   assign o_width14 = width_out_q;
   assign o_outputs_valid = valid_q;
   assign o_frame_clock = frame_clk_q;
   assign o_bit_clock = bit_clk_q;

endmodule

// ---- adc_cfg_chk.sv ----
/* Port assertions for the converter control block.
   Bound to the top module; one clock, sync low reset. */
`timescale 1ns/1ps
module adc_cfg_chk
   import adc_cfg_pkg::*;
(
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   input wire logic i_power_down,
   input wire logic i_deep_sleep,
   input wire logic [5:0] o_full_scale_trim,
   input wire logic [5:0] o_trim_steps,
   input wire logic [2:0] o_core_perf,
   input wire logic o_core_perf_reserved,
   input wire logic [1:0] o_common_mode_buffer_strength,
   input wire logic o_cm_buffer_enable,
   input wire logic [1:0] o_clock_range,
   input wire logic o_width14,
   input wire logic o_outputs_valid,
   input wire logic [NUM_CH-1:0] o_lane,
   input wire logic o_frame_clock,
   input wire logic o_bit_clock
);
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (!i_rst_n);
   // ----------------------------
   // Cycles since last sleep pin
   // ----------------------------
   logic [9:0] quiet_q;
   logic [9:0] need;
   assign need = o_clock_range == 2'h0 ? STARTUP_R0 :
      o_clock_range == 2'h1 ? STARTUP_R1 :
      o_clock_range == 2'h2 ? STARTUP_R2 : STARTUP_R3;
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rst_n || i_power_down || i_deep_sleep)
         quiet_q <= 10'h000;
      else if (quiet_q != 10'h3ff)
         quiet_q <= quiet_q + 10'h001;
   end
   // ----------------------------
   // Assertions
   // ----------------------------
   trim_steps_a: assert property (
      o_trim_steps == 6'(o_full_scale_trim - 6'h20))
      else $error("trim step count wrong");
   buf_enable_a: assert property (
      o_cm_buffer_enable == (o_common_mode_buffer_strength != VCM_OFF))
      else $error("buffer enable wrong");
   perf_flag_a: assert property (
      o_core_perf_reserved == (o_core_perf inside {3'h1, 3'h2, 3'h3}))
      else $error("reserved flag wrong");
   bit_toggle_a: assert property (
      $past(i_rst_n) |-> o_bit_clock != $past(o_bit_clock))
      else $error("bit clock stuck");
   frame_high_a: assert property (
      $rose(o_frame_clock) && !o_width14 && $stable(o_width14) &&
      $past(o_width14, 3) == o_width14
      |-> o_frame_clock [*6] ##1 !o_frame_clock)
      else $error("frame clock length wrong");
   frame_wide_a: assert property (
      $rose(o_frame_clock) && o_width14 && $stable(o_width14) &&
      $past(o_width14, 3) == o_width14
      |-> o_frame_clock [*7] ##1 !o_frame_clock)
      else $error("wide frame clock length wrong");
   wide_lsb_a: assert property (
      $rose(o_frame_clock) && o_width14 && $stable(o_width14) &&
      $past(o_width14, 3) == o_width14 |-> o_lane == 8'h00)
      else $error("wide word lsb not zero");
   sleep_drop_a: assert property (
      (i_power_down || i_deep_sleep) [*5] |-> !o_outputs_valid)
      else $error("valid during sleep");
   wake_early_a: assert property (
      $rose(o_outputs_valid) |-> quiet_q + 10'h002 >= need)
      else $error("valid too early");
   wake_late_a: assert property (
      quiet_q == need + 10'h008 |-> o_outputs_valid)
      else $error("valid too late");
   cover property ($rose(o_outputs_valid));
   cover property ($rose(o_frame_clock) && o_width14);
   cover property (o_core_perf_reserved);
endmodule

bind adc_trim_and_startup_ctrl adc_cfg_chk i_chk (.*);

// ---- adc_lane_rx.sv ----
/* Receiver model: captures the eight serial lanes into words.
   Word starts at frame clock rise, one bit per ref clock. */
`timescale 1ns/1ps
module adc_lane_rx
   import adc_cfg_pkg::*;
(
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   input wire logic i_width14,
   input wire logic i_frame_clock,
   input wire logic [NUM_CH-1:0] i_lane,
   output logic [WORD_W-1:0] o_word [NUM_CH],
   output logic o_word_done
);
   logic fc_q;
   logic [3:0] idx_q;
   logic [3:0] k;
   assign k = (i_frame_clock && !fc_q) ? 4'h0 : idx_q;
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rst_n)
      begin
         fc_q <= 1'b0;
         idx_q <= 4'h0;
         o_word_done <= 1'b0;
      end
      else
      begin
         fc_q <= i_frame_clock;
         idx_q <= k + 4'h1;
         o_word_done <= k == (i_width14 ? LEN_14 : LEN_12) - 4'h1;
         for (int c = 0; c < NUM_CH; c++)
            o_word[c][k] <= i_lane[c];
      end
   end
endmodule

// ---- testbench.sv ----
/* Self-checking bench for the converter control block.
   Serial control and sleep pins driven here; lanes go to a model. */
`timescale 1ns/1ps
module testbench;
   import adc_cfg_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic sclk = 1'b0;
   logic sdat = 1'b0;
   logic sen_n = 1'b1;
   logic pd = 1'b0;
   logic ds = 1'b0;
   logic [NUM_CH*CODE_W-1:0] code = '0;
   logic [5:0] trim, steps;
   logic [2:0] perf;
   logic [1:0] cmb, rng;
   logic rsv, cme, w14, valid, fc, bc, rxd;
   logic [NUM_CH-1:0] lane;
   logic [WORD_W-1:0] rxw [NUM_CH];
   logic [31:0] seed = 32'h1fdf9873;
   int n_errors = 0;
   int check_count = 0;
   int cyc = 0;
   initial forever #4 clk = ~clk;
   adc_trim_and_startup_ctrl i_adc_trim_and_startup_ctrl (
      .i_ref_clk(clk), .i_rst_n(rst_n), .i_ctrl_sclk(sclk),
      .i_ctrl_sdata(sdat), .i_ctrl_sen_n(sen_n), .i_power_down(pd),
      .i_deep_sleep(ds), .i_conv_code(code), .o_full_scale_trim(trim),
      .o_trim_steps(steps), .o_core_perf(perf),
      .o_core_perf_reserved(rsv), .o_common_mode_buffer_strength(cmb),
      .o_cm_buffer_enable(cme), .o_clock_range(rng), .o_width14(w14),
      .o_outputs_valid(valid), .o_lane(lane), .o_frame_clock(fc),
      .o_bit_clock(bc));
   adc_lane_rx i_adc_lane_rx (.i_ref_clk(clk), .i_rst_n(rst_n),
      .i_width14(w14), .i_frame_clock(fc), .i_lane(lane),
      .o_word(rxw), .o_word_done(rxd));
   // ----------------------------
   // Helpers
   // ----------------------------
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function automatic int startup(input int r);
      return r == 0 ? 992 : r == 1 ? 640 : r == 2 ? 420 : 260;
   endfunction
   function automatic logic [13:0] word_of(input logic [12:0] c,
      input bit w);
      return w ? {c, 1'b0} : {2'h0, c[12:1]};
   endfunction
   task automatic chk(input logic [13:0] g, input logic [13:0] e);
      check_count++;
      if (g !== e)
      begin
         n_errors++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic chk_in(input int g, input int lo, input int hi);
      check_count++;
      if (g < lo || g > hi)
      begin
         n_errors++;
         $display("[ERR] %0t wake %0d not in %0d..%0d", $time, g, lo, hi);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      logic [23:0] f;
      f = {a, d};
      sen_n = 1'b0;
      for (int i = 23; i >= 0; i--)
      begin
         sdat = f[i];
         repeat (3) @(negedge clk);
         sclk = 1'b1;
         repeat (3) @(negedge clk);
         sclk = 1'b0;
      end
      repeat (3) @(negedge clk);
      sen_n = 1'b1;
      repeat (10) @(negedge clk);
   endtask
   task automatic wait_valid(input int n);
      int t;
      t = 0;
      while (valid !== 1'b1 && t < 1200)
      begin
         @(negedge clk);
         t++;
      end
      chk_in(t, n, n + 8);
      $display("wake test done");
   endtask
   task automatic wake(input bit deep, input int n);
      ds = deep;
      pd = !deep;
      repeat (20) @(negedge clk);
      chk(14'(valid), 14'h0);
      ds = 1'b0;
      pd = 1'b0;
      wait_valid(n);
   endtask
   task automatic data(input bit w);
      logic [12:0] cv;
      for (int c = 2; c < NUM_CH; c++)
         code[c*CODE_W +: CODE_W] = 13'(rnd());
      code[25:0] = {13'h1fff, 13'h0000};
      repeat (40) @(negedge clk);
      while (rxd !== 1'b1)
         @(negedge clk);
      for (int c = 0; c < NUM_CH; c++)
      begin
         cv = code[c*CODE_W +: CODE_W];
         chk(w ? rxw[c] : 14'(rxw[c][11:0]), word_of(cv, w));
      end
      $display("lane test done");
   endtask
   task automatic wrap_up();
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         n_errors++;
         $display("[ERR] %0t timeout", $time);
         wrap_up();
      end
   end
   // ----------------------------
   // Main sequence
   // ----------------------------
   initial
   begin
      logic [5:0] tv [5];
      logic [2:0] pv;
      repeat (20) @(negedge clk);
      chk(14'(trim), 14'h20);
      chk(14'(perf), 14'h0);
      chk(14'(cmb), 14'h1);
      chk(14'(rng), 14'h0);
      chk(14'(valid), 14'h0);
      $display("reset test done");
      rst_n = 1'b1;
      wait_valid(992);
      tv = '{6'h00, 6'h3f, 6'h20, 6'h1f, 6'(rnd())};
      foreach (tv[i])
      begin
         wr(ADDR_FULL_SCALE, {10'h000, tv[i]});
         chk(14'(trim), 14'(tv[i]));
         chk(14'(steps), 14'(6'(tv[i] - 6'h20)));
      end
      wr(8'h60, 16'hffff);
      chk(14'(trim), 14'(tv[4]));
      $display("trim test done");
      for (int i = 0; i < 5; i++)
      begin
         pv = i == 0 ? 3'h0 : 3'(i + 3);
         wr(ADDR_CORE_POWER_VCM, {10'h000, 2'(i), 1'b0, pv});
         chk(14'(perf), 14'(pv));
         chk(14'(cmb), 14'(i % 4));
         chk(14'(cme), 14'(i % 4 != 0));
      end
      wr(ADDR_CORE_POWER_VCM, 16'h0012);
      chk(14'(rsv), 14'h1);
      wr(ADDR_CORE_POWER_VCM, 16'h0010);
      chk(14'(rsv), 14'h0);
      $display("power test done");
      for (int r = 0; r < 4; r++)
      begin
         wr(ADDR_CLOCK_RANGE, 16'(r));
         chk(14'(rng), 14'(r));
         wake(r[0], startup(r));
      end
      data(1'b0);
      wr(ADDR_OUT_BITS, 16'h0002);
      chk(14'(w14), 14'h1);
      data(1'b1);
      wrap_up();
   end
endmodule
